// *** dv/nested_exception_prioritizer_tb.sv ***
// self-checking bench of the vectored priority controller
`timescale 1ns/1ns
`default_nettype none
module nested_exception_prioritizer_tb
  import vpc_pkg::*;
;
  logic aclk, aresetn, nmi_in, bus_fault_imp, mm_fault, bus_fault_pre, usage_fault;
  logic supv_call, debug_req, tick_event, core_return, hold;
  logic [NUM_IRQ-1:0] irq_in;
  logic exc_take, exc_stack, exc_tail, exc_unstack, sp_load, handler_mode;
  logic [5:0] exc_vector;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int n_mismatch, n_compared, n_cyc, n, m;
  int m_prio[64];
  logic [9:0] exp_q[$];
  vpc_core i_dut (.aclk(aclk), .aresetn(aresetn), .irq_in(irq_in), .nmi_in(nmi_in),
    .bus_fault_imp(bus_fault_imp), .mm_fault(mm_fault), .bus_fault_pre(bus_fault_pre),
    .usage_fault(usage_fault), .supv_call(supv_call), .debug_req(debug_req),
    .tick_event(tick_event), .core_return(core_return), .exc_take(exc_take),
    .exc_vector(exc_vector), .exc_stack(exc_stack), .exc_tail(exc_tail),
    .exc_unstack(exc_unstack), .sp_load(sp_load), .handler_mode(handler_mode),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  vpc_core_partner i_core (.aclk(aclk), .aresetn(aresetn), .exc_take(exc_take),
    .exc_stack(exc_stack), .exc_unstack(exc_unstack), .handler_mode(handler_mode),
    .hold(hold), .core_return(core_return));
  // =====================================================================
  // reference model and checks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // event code: unstack, sp_load, tail, stack, vector
  function automatic logic [9:0] ev(input int v, input int k);
    ev = {k == 3, k == 2, k == 1, k == 0, 6'(k == 3 ? 0 : v)};
  endfunction : ev
  function automatic int rank(input int v);
    rank = v <= 3 ? v - 1 : 4 + m_prio[v];
  endfunction : rank
  function automatic int pick(input int a, input int b);
    pick = (rank(b) < rank(a) || (rank(b) == rank(a) && b < a)) ? b : a;
  endfunction : pick
  task automatic chain2(input int a, input int b);
    int f;
    f = pick(a, b);
    exp_q.push_back(ev(f, 0));
    exp_q.push_back(ev(f == a ? b : a, 1));
    exp_q.push_back(ev(0, 3));
  endtask : chain2
  function automatic logic [31:0] prio_word(input int w);
    int sv[7] = '{4, 5, 6, 11, 12, 14, 15};
    int v;
    prio_word = '0;
    for (int j = 0; j < 8; j++)
    begin
      v = (w == 4) ? (j < 7 ? sv[j] : 0) : 16 + 8 * w + j;
      if (v > 0 && v < 42)
        prio_word[4*j +: 3] = 3'(m_prio[v]);
    end
  endfunction : prio_word
  function automatic logic [7:0] paddr(input int w);
    paddr = w == 4 ? OFF_SYSPRIO : OFF_PRIO0 + 8'(4 * w);
  endfunction : paddr
  always @(posedge aclk)
    if (exc_take === 1'b1 || exc_unstack === 1'b1)
      check("exception event", {22'h0, exc_unstack, sp_load, exc_tail, exc_stack,
        exc_take ? exc_vector : 6'h00}, {22'h0, exp_q.size() != 0 ? exp_q.pop_front() : 10'h0});
  // =====================================================================
  // bus and pin drivers
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      ad = ad | (awready === 1'b1);
      wd = wd | (wready === 1'b1);
      awvalid <= !ad;
      wvalid <= !wd;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    check("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    check("rresp", {30'h0, rresp}, {30'h0, er});
    if (er == RESP_OKAY)
      check("rdata", rdata, ed);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd
  task automatic prio_sync(input bit wr);
    for (int w = 0; w < 5; w++)
    begin
      if (wr)
        axi_wr(paddr(w), prio_word(w), RESP_OKAY);
      axi_rd(paddr(w), prio_word(w), RESP_OKAY);
    end
  endtask : prio_sync
  // pin chosen by code, high for len cycles, then one low cycle
  task automatic pulse(input int sel, input int len);
    for (int k = 0; k <= len; k++)
    begin
      case (sel)
        0: supv_call <= k < len;
        1: tick_event <= k < len;
        2: nmi_in <= k < len;
        3: mm_fault <= k < len;
        4: bus_fault_pre <= k < len;
        5: usage_fault <= k < len;
        6: bus_fault_imp <= k < len;
        default: debug_req <= k < len;
      endcase
      @(posedge aclk);
    end
  endtask : pulse
  task automatic drain();
    while (exp_q.size() != 0)
      @(posedge aclk);
    repeat (12) @(posedge aclk);
    check("handler mode", {31'h0, handler_mode}, 32'h0);
  endtask : drain
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // =====================================================================
  // clock, watchdog and scenarios
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    n_cyc++;
    if (n_cyc == 40000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial
  begin
    {aresetn, nmi_in, bus_fault_imp, mm_fault, bus_fault_pre, usage_fault} = '0;
    {supv_call, debug_req, tick_event, awvalid, wvalid, bready, arvalid, rready} = '0;
    {irq_in, awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    hold = 1'b0;
    foreach (m_prio[i]) m_prio[i] = 0;
    void'($urandom(43));
    exp_q.push_back(ev(1, 2));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    prio_sync(0);
    axi_rd(OFF_CTRL, 32'h0, RESP_OKAY);
    for (int i = 0; i < 2; i++)
    begin
      exp_q.push_back(ev(3, 0));
      exp_q.push_back(ev(0, 3));
      if (i == 0)
        axi_rd(8'h40, 32'h0, RESP_SLVERR);
      else
        axi_wr(8'h80, 32'h5a, RESP_SLVERR);
      drain();
    end
    for (int r = 0; r < 2; r++)
    begin
      if (r == 1)
      begin
        m_prio[11] = 3;
        m_prio[15] = 1;
        prio_sync(1);
      end
      chain2(11, 15);
      supv_call <= 1'b1;
      tick_event <= 1'b1;
      @(posedge aclk);
      supv_call <= 1'b0;
      tick_event <= 1'b0;
      drain();
    end
    // second pass: grouping makes both one preemption level, so tick waits
    for (int g = 0; g < 2; g++)
    begin
      axi_wr(OFF_CTRL, g ? 32'h20 : 32'h0, RESP_OKAY);
      hold <= 1'b1;
      exp_q.push_back(ev(11, 0));
      exp_q.push_back(ev(15, g));
      if (g == 0)
        exp_q.push_back(ev(0, 3));
      exp_q.push_back(ev(0, 3));
      pulse(0, 1);
      repeat (6) @(posedge aclk);
      pulse(1, 1);
      repeat (6) @(posedge aclk);
      hold <= 1'b0;
      drain();
    end
    hold <= 1'b1;
    exp_q.push_back(ev(11, 0));
    exp_q.push_back(ev(2, 0));
    exp_q.push_back(ev(0, 3));
    exp_q.push_back(ev(0, 3));
    pulse(0, 1);
    repeat (4) @(posedge aclk);
    pulse(2, 3);
    repeat (8) @(posedge aclk);
    hold <= 1'b0;
    drain();
    for (int k = 0; k < 4; k++)
      for (int en = 0; en < 2; en++)
      begin
        axi_wr(OFF_CTRL, en ? 32'h7 : 32'h0, RESP_OKAY);
        exp_q.push_back(ev(en ? (k == 3 ? 5 : 4 + k) : 3, 0));
        exp_q.push_back(ev(0, 3));
        case (k)
          0: pulse(3, 1);
          1: pulse(4, 1);
          2: pulse(5, 1);
          default: pulse(6, 3);
        endcase
        drain();
      end
    pulse(7, 1);
    drain();
    axi_wr(OFF_CTRL, 32'hf, RESP_OKAY);
    exp_q.push_back(ev(12, 0));
    exp_q.push_back(ev(0, 3));
    pulse(7, 1);
    drain();
    exp_q.push_back(ev(14, 0));
    exp_q.push_back(ev(0, 3));
    axi_wr(OFF_CTRL, 32'h10f, RESP_OKAY);
    drain();
    for (int t = 0; t < 4; t++)
    begin
      n = $urandom % 26;
      m = (n + 1 + $urandom % 25) % 26;
      m_prio[16+n] = $urandom % 8;
      m_prio[16+m] = $urandom % 8;
      prio_sync(1);
      axi_wr(OFF_EN_CLR, 32'h3ffffff, RESP_OKAY);
      irq_in[n] <= 1'b1;
      irq_in[m] <= 1'b1;
      repeat (8) @(posedge aclk);
      chain2(16 + n, 16 + m);
      axi_wr(OFF_EN_SET, (32'h1 << n) | (32'h1 << m), RESP_OKAY);
      drain();
      irq_in <= '0;
      @(posedge aclk);
    end
    print_verdict();
  end
endmodule : nested_exception_prioritizer_tb
`default_nettype wire

// *** dv/vpc_core_partner.sv ***
// behavioural model of the processor core that finishes handlers
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// core model
module vpc_core_partner (
  input  wire logic aclk,         // system clock
  input  wire logic aresetn,      // sync reset, low
  input  wire logic exc_take,     // activation pulse
  input  wire logic exc_stack,    // fresh entry
  input  wire logic exc_unstack,  // state restored
  input  wire logic handler_mode, // handler state
  input  wire logic hold,         // bench stalls returns
  output logic      core_return   // handler done pulse
);
  int depth;
  int cnt;
  // latency drawn per handler so prompt and slow returns both occur
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      depth <= 0;
      cnt <= 0;
      core_return <= 1'b0;
    end
    else
    begin
      core_return <= 1'b0;
      depth <= depth + int'(exc_stack === 1'b1) - int'(exc_unstack === 1'b1);
      if (exc_take === 1'b1 || exc_unstack === 1'b1)
        cnt <= 1 + $urandom % 6;
      else if (cnt != 0)
        cnt <= cnt - 1;
      else if (depth > 0 && !hold && handler_mode === 1'b1)
      begin
        core_return <= 1'b1;
        cnt <= 3;
      end
    end
  end
endmodule : vpc_core_partner
`default_nettype wire

// *** shared/vpc_pkg.sv ***
// constants and types of the vectored priority controller
package vpc_pkg;
  localparam int         NUM_IRQ     = 26;
  localparam int         NUM_VEC     = 42;
  localparam int         NUM_SYS     = 7;
  localparam int         PRIO_W      = 3;
  localparam logic [2:0] PRIO_RST    = 3'h0;
  localparam logic [4:0] RANK_IDLE   = 5'h1f;
  localparam logic [4:0] RANK_BASE   = 5'h04;
  localparam logic [5:0] VEC_SP      = 6'h00;
  localparam logic [5:0] VEC_RESET   = 6'h01;
  localparam logic [5:0] VEC_NMI     = 6'h02;
  localparam logic [5:0] VEC_HARD    = 6'h03;
  localparam logic [5:0] VEC_MEM     = 6'h04;
  localparam logic [5:0] VEC_BUS     = 6'h05;
  localparam logic [5:0] VEC_USAGE   = 6'h06;
  localparam logic [5:0] VEC_SUPV    = 6'h0b;
  localparam logic [5:0] VEC_DEBUG   = 6'h0c;
  localparam logic [5:0] VEC_PEND_RQ = 6'h0e;
  localparam logic [5:0] VEC_TICK    = 6'h0f;
  localparam int         IRQ_BASE    = 16;
  localparam logic [7:0] OFF_EN_SET  = 8'h00;
  localparam logic [7:0] OFF_EN_CLR  = 8'h04;
  localparam logic [7:0] OFF_PND_SET = 8'h08;
  localparam logic [7:0] OFF_PND_CLR = 8'h0c;
  localparam logic [7:0] OFF_PRIO0   = 8'h10;
  localparam logic [7:0] OFF_SYSPRIO = 8'h20;
  localparam logic [7:0] OFF_CTRL    = 8'h24;
  localparam logic [7:0] OFF_STATUS  = 8'h28;
  localparam int         CTL_MM      = 0;
  localparam int         CTL_BF      = 1;
  localparam int         CTL_UF      = 2;
  localparam int         CTL_DM      = 3;
  localparam int         CTL_GRP     = 4;
  localparam int         CTL_PSV_SET = 8;
  localparam int         CTL_PSV_CLR = 9;
  localparam int         STAT_ACT    = 0;
  localparam int         STAT_PEND   = 8;
  localparam int         STAT_HMODE  = 16;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN  = 2'b01
  } vpc_state_t;
endpackage : vpc_pkg

// *** src/vpc_core.sv ***
// exception prioritizer with axi4-lite register slave
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module vpc_core
  import vpc_pkg::*;
(
  input  wire logic                aclk,          // system clock
  input  wire logic                aresetn,       // sync reset, low
  input  wire logic [NUM_IRQ-1:0]  irq_in,        // async irq lines
  input  wire logic                nmi_in,        // async nmi
  input  wire logic                bus_fault_imp, // async imprecise fault
  input  wire logic                mm_fault,      // protection mismatch pulse
  input  wire logic                bus_fault_pre, // precise bus fault pulse
  input  wire logic                usage_fault,   // usage fault pulse
  input  wire logic                supv_call,     // supervisor call pulse
  input  wire logic                debug_req,     // debug monitor pulse
  input  wire logic                tick_event,    // system tick pulse
  input  wire logic                core_return,   // handler done pulse
  output logic                     exc_take,      // activation pulse
  output logic [5:0]               exc_vector,    // vector to fetch
  output logic                     exc_stack,     // start state save
  output logic                     exc_tail,      // tail-chain entry
  output logic                     exc_unstack,   // restore state
  output logic                     sp_load,       // load entry 0
  output logic                     handler_mode,  // in handler state
  input  wire logic [7:0]          awaddr,        // axi write addr
  input  wire logic                awvalid,       // axi
  output logic                     awready,       // axi
  input  wire logic [31:0]         wdata,         // axi
  input  wire logic [3:0]          wstrb,         // axi
  input  wire logic                wvalid,        // axi
  output logic                     wready,        // axi
  output logic [1:0]               bresp,         // axi
  output logic                     bvalid,        // axi
  input  wire logic                bready,        // axi
  input  wire logic [7:0]          araddr,        // axi read addr
  input  wire logic                arvalid,       // axi
  output logic                     arready,       // axi
  output logic [31:0]              rdata,         // axi
  output logic [1:0]               rresp,         // axi
  output logic                     rvalid,        // axi
  input  wire logic                rready         // axi
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [NUM_IRQ+1:0]             s1;
    logic [NUM_IRQ+1:0]             s2;
    logic [NUM_IRQ+1:0]             s3;
    logic [NUM_VEC-1:0]             pend;
    logic [NUM_VEC-1:0]             act;
    logic [NUM_IRQ-1:0]             en;
    logic [NUM_IRQ-1:0][PRIO_W-1:0] ip;
    logic [NUM_SYS-1:0][PRIO_W-1:0] sp;
    logic [3:0]                     fen;
    logic [1:0]                     grp;
    vpc_state_t                     st;
    logic                           take;
    logic                           tail;
    logic                           stk;
    logic                           ustk;
    logic                           spld;
    logic                           hmode;
    logic [5:0]                     vec;
    logic                           awok;
    logic                           wok;
    logic [7:0]                     awa;
    logic [31:0]                    wd;
    logic [3:0]                     ws;
    logic                           awr;
    logic                           wr;
    logic                           bv;
    logic [1:0]                     br;
    logic                           arr;
    logic                           rv;
    logic [31:0]                    rd;
    logic [1:0]                     rr;
  } vpc_regs_t;

  vpc_regs_t q;
  vpc_regs_t n;

  // ==========================================================
  // priority helpers
  function automatic logic [2:0] prio_f(
    input int                             v,
    input logic [NUM_IRQ-1:0][PRIO_W-1:0] ip,
    input logic [NUM_SYS-1:0][PRIO_W-1:0] sp
  );
    logic [2:0] p;
    p = PRIO_RST;
    case (v)
      4:       p = sp[0];
      5:       p = sp[1];
      6:       p = sp[2];
      11:      p = sp[3];
      12:      p = sp[4];
      14:      p = sp[5];
      15:      p = sp[6];
      default: if (v >= IRQ_BASE) p = ip[5'(v - IRQ_BASE)];
    endcase
    return p;
  endfunction : prio_f

  // fixed ranks sit above every settable level
  function automatic logic [4:0] rank_f(
    input int         v,
    input logic [2:0] p,
    input logic [2:0] m
  );
    logic [4:0] r;
    case (v)
      1:       r = 5'h00;
      2:       r = 5'h01;
      3:       r = 5'h02;
      default: r = RANK_BASE + {2'b00, p & m};
    endcase
    return r;
  endfunction : rank_f

  // {unmapped, word}
  function automatic logic [32:0] rd_f(
    input logic [7:0]  a,
    input vpc_regs_t   s,
    input logic [31:0] stat
  );
    logic [31:0] w;
    logic        bad;
    w   = 32'h0;
    bad = 1'b0;
    case (a)
      OFF_EN_SET, OFF_EN_CLR:   w[NUM_IRQ-1:0] = s.en;
      OFF_PND_SET, OFF_PND_CLR: w[NUM_IRQ-1:0] = s.pend[NUM_VEC-1:IRQ_BASE];
      OFF_SYSPRIO:
        for (int i = 0; i < NUM_SYS; i++) w[4*i+:3] = s.sp[i];
      OFF_CTRL:
      begin
        w[3:0]           = s.fen;
        w[CTL_GRP+:2]    = s.grp;
        w[CTL_PSV_SET]   = s.pend[VEC_PEND_RQ];
      end
      OFF_STATUS:               w = stat;
      default:
        if (a >= OFF_PRIO0 && a < OFF_SYSPRIO && a[1:0] == 2'h0)
        begin
          for (int i = 0; i < NUM_IRQ; i++)
            if (a == OFF_PRIO0 + 8'(4 * (i / 8))) w[4*(i%8)+:3] = s.ip[i];
        end
        else
          bad = 1'b1;
    endcase
    return {bad, w};
  endfunction : rd_f

  // ==========================================================
  // next state
  logic [2:0]         msk;
  logic [NUM_VEC-1:0] elig;
  logic [NUM_VEC-1:0] act2;
  logic [5:0]         best_v;
  logic [4:0]         best_f;
  logic [4:0]         best_p;
  logic [5:0]         cur_v;
  logic [4:0]         cur_r;
  logic [4:0]         ex2;
  logic [31:0]        stat;
  logic [32:0]        rres;
  logic [32:0]        wres;
  logic [31:0]        wm;
  logic               werr;
  logic [NUM_IRQ-1:0] irise;

  always_comb
  begin
    n        = q;
    n.take   = 1'b0;
    n.tail   = 1'b0;
    n.stk    = 1'b0;
    n.ustk   = 1'b0;
    n.spld   = 1'b0;
    werr     = 1'b0;
    // only the second and third stages feed any logic, as an edge detect
    n.s1     = {bus_fault_imp, nmi_in, irq_in};
    n.s2     = q.s1;
    n.s3     = q.s2;
    msk      = 3'(3'h7 << q.grp);
    // interrupts wait for their enable, system ones do not
    elig     = q.pend & {q.en, 16'hffff};
    best_v   = VEC_SP;
    best_f   = RANK_IDLE;
    cur_v    = VEC_SP;
    cur_r    = RANK_IDLE;
    for (int v = 0; v < NUM_VEC; v++)
    begin
      // strict compare keeps the lower vector on a tie
      if (elig[v] && rank_f(v, prio_f(v, q.ip, q.sp), 3'h7) < best_f)
      begin
        best_f = rank_f(v, prio_f(v, q.ip, q.sp), 3'h7);
        best_v = 6'(v);
      end
      if (q.act[v] && rank_f(v, prio_f(v, q.ip, q.sp), msk) < cur_r)
      begin
        cur_r = rank_f(v, prio_f(v, q.ip, q.sp), msk);
        cur_v = 6'(v);
      end
    end
    best_p = rank_f(int'(best_v), prio_f(int'(best_v), q.ip, q.sp), msk);
    act2   = q.act;
    act2[cur_v] = 1'b0;
    ex2    = RANK_IDLE;
    for (int v = 0; v < NUM_VEC; v++)
      if (act2[v] && rank_f(v, prio_f(v, q.ip, q.sp), msk) < ex2)
        ex2 = rank_f(v, prio_f(v, q.ip, q.sp), msk);
    stat = 32'h0;
    stat[STAT_ACT+:6]  = cur_v;
    stat[STAT_PEND+:6] = best_v;
    stat[STAT_HMODE]   = q.hmode;

    // ========================================================
    // activation sequencing
    case (q.st)
      ST_BOOT:
      begin
        n.spld  = 1'b1;
        n.take  = 1'b1;
        n.vec   = VEC_RESET;
        n.hmode = 1'b0; // reset runs at base level
        n.st    = ST_RUN;
      end
      ST_RUN:
        if (core_return && q.hmode)
        begin
          n.act[cur_v] = 1'b0;
          if (best_f != RANK_IDLE && best_p < ex2)
          begin
            n.take         = 1'b1;
            n.tail         = 1'b1;
            n.vec          = best_v;
            n.act[best_v]  = 1'b1;
            n.pend[best_v] = 1'b0;
          end
          else
          begin
            n.ustk  = 1'b1;
            n.hmode = |act2;
          end
        end
        else if (best_f != RANK_IDLE && best_p < cur_r)
        begin
          n.take         = 1'b1;
          n.stk          = 1'b1; // fetch and save together
          n.vec          = best_v;
          n.act[best_v]  = 1'b1;
          n.pend[best_v] = 1'b0;
          n.hmode        = 1'b1;
        end
      default: n.st = ST_BOOT;
    endcase

    // ========================================================
    // register bus
    if (q.awr && awvalid)
    begin
      n.awok = 1'b1;
      n.awa  = awaddr;
    end
    if (q.wr && wvalid)
    begin
      n.wok = 1'b1;
      n.wd  = wdata;
      n.ws  = wstrb;
    end
    wres = rd_f(q.awa, q, stat);
    wm   = {{8{q.ws[3]}}, {8{q.ws[2]}}, {8{q.ws[1]}}, {8{q.ws[0]}}};
    if (q.awok && q.wok && !q.bv)
    begin
      n.awok = 1'b0;
      n.wok  = 1'b0;
      n.bv   = 1'b1;
      n.br   = wres[32] ? RESP_SLVERR : RESP_OKAY;
      werr   = wres[32];
      case (q.awa)
        OFF_EN_SET: n.en = q.en | NUM_IRQ'(q.wd & wm);
        OFF_EN_CLR: n.en = q.en & ~NUM_IRQ'(q.wd & wm);
        OFF_PND_SET:
          n.pend[NUM_VEC-1:IRQ_BASE] = n.pend[NUM_VEC-1:IRQ_BASE] | NUM_IRQ'(q.wd & wm);
        OFF_PND_CLR:
          n.pend[NUM_VEC-1:IRQ_BASE] = n.pend[NUM_VEC-1:IRQ_BASE] & ~NUM_IRQ'(q.wd & wm);
        OFF_SYSPRIO:
          for (int i = 0; i < NUM_SYS; i++)
            if (q.ws[i/2]) n.sp[i] = q.wd[4*i+:3];
        OFF_CTRL:
        begin
          if (q.ws[0])
          begin
            n.fen = q.wd[3:0];
            n.grp = q.wd[CTL_GRP+:2];
          end
          if (q.ws[1] && q.wd[CTL_PSV_CLR]) n.pend[VEC_PEND_RQ] = 1'b0;
          if (q.ws[1] && q.wd[CTL_PSV_SET]) n.pend[VEC_PEND_RQ] = 1'b1;
        end
        default:
          for (int i = 0; i < NUM_IRQ; i++)
            if (q.awa == OFF_PRIO0 + 8'(4 * (i / 8)) && q.ws[(i % 8) / 2])
              n.ip[i] = q.wd[4*(i%8)+:3];
      endcase
    end
    if (q.bv && bready) n.bv = 1'b0;
    n.awr = !n.awok && !n.bv;
    n.wr  = !n.wok && !n.bv;
    rres  = rd_f(araddr, q, stat);
    if (q.arr && arvalid)
    begin
      n.rv = 1'b1;
      n.rd = rres[31:0];
      n.rr = rres[32] ? RESP_SLVERR : RESP_OKAY;
      werr = werr | rres[32];
    end
    if (q.rv && rready) n.rv = 1'b0;
    n.arr = !n.rv;

    // ========================================================
    // event capture, applied last so a set beats any clear
    irise = q.s2[NUM_IRQ-1:0] & ~q.s3[NUM_IRQ-1:0];
    n.pend[NUM_VEC-1:IRQ_BASE] = n.pend[NUM_VEC-1:IRQ_BASE] | irise;
    if (q.s2[NUM_IRQ] && !q.s3[NUM_IRQ]) n.pend[VEC_NMI] = 1'b1;
    // imprecise fault has no priority check, only the enable
    if (q.s2[NUM_IRQ+1] && !q.s3[NUM_IRQ+1])
      n.pend[q.fen[CTL_BF] ? VEC_BUS : VEC_HARD] = 1'b1;
    // synchronous faults escalate when they cannot activate now
    if (mm_fault)
      n.pend[(q.fen[CTL_MM] && rank_f(4, q.sp[0], msk) < cur_r)
             ? VEC_MEM : VEC_HARD] = 1'b1;
    if (bus_fault_pre || werr)
      n.pend[(q.fen[CTL_BF] && rank_f(5, q.sp[1], msk) < cur_r)
             ? VEC_BUS : VEC_HARD] = 1'b1;
    if (usage_fault)
      n.pend[(q.fen[CTL_UF] && rank_f(6, q.sp[2], msk) < cur_r)
             ? VEC_USAGE : VEC_HARD] = 1'b1;
    if (supv_call) n.pend[VEC_SUPV] = 1'b1;
    if (debug_req && q.fen[CTL_DM]) n.pend[VEC_DEBUG] = 1'b1;
    if (tick_event) n.pend[VEC_TICK] = 1'b1;
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q    <= '0;
      q.st <= ST_BOOT;
    end
    else
      q <= n;
  end

  assign exc_take     = q.take;
  assign exc_vector   = q.vec;
  assign exc_stack    = q.stk;
  assign exc_tail     = q.tail;
  assign exc_unstack  = q.ustk;
  assign sp_load      = q.spld;
  assign handler_mode = q.hmode;
  assign awready      = q.awr;
  assign wready       = q.wr;
  assign bvalid       = q.bv;
  assign bresp        = q.br;
  assign arready      = q.arr;
  assign rvalid       = q.rv;
  assign rdata        = q.rd;
  assign rresp        = q.rr;

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_boot;
    $rose(aresetn) |=> sp_load && exc_take && exc_vector == VEC_RESET;
  endproperty
  a_boot: assert property (p_boot) else $error("no reset entry");

  property p_prio_rst;
    $past(!aresetn) |-> q.ip == '0 && q.sp == '0;
  endproperty
  a_prio_rst: assert property (p_prio_rst) else $error("prio not zero");

  property p_fetch_par;
    exc_take && !exc_tail && !sp_load |-> exc_stack && handler_mode;
  endproperty
  a_fetch_par: assert property (p_fetch_par) else $error("no stacking");

  property p_tail;
    exc_tail |-> exc_take && !exc_stack && !exc_unstack && $past(core_return);
  endproperty
  a_tail: assert property (p_tail) else $error("bad tail chain");

  property p_preempt;
    exc_take && exc_stack |-> $past(best_p) < $past(cur_r);
  endproperty
  a_preempt: assert property (p_preempt) else $error("weak preemption");

  property p_nmi;
    q.pend[VEC_NMI] && cur_r > 5'h01 && q.st == ST_RUN
      |=> exc_take && exc_vector == VEC_NMI;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not taken");

  property p_unmapped;
    $rose(bvalid) && bresp == RESP_SLVERR |-> q.pend[VEC_BUS] || q.pend[VEC_HARD];
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no bus fault");

  property p_irq_vec;
    $rose(q.pend[IRQ_BASE]) && !$rose(bvalid) |-> $past(q.s2[0], 1) && !$past(q.s3[0], 1);
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("irq 0 misplaced");

endmodule : vpc_core
`default_nettype wire
